// ---- alert_thermal_pkg.sv ----
package alert_thermal_pkg;

  // ------------------------------------------------------------
  // Register offsets.
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_ONE_ADDR     = 8'h41;
  localparam logic [7:0] STATUS_TWO_ADDR     = 8'h42;
  localparam logic [7:0] ALERT_MASK_ONE_ADDR = 8'h74;
  localparam logic [7:0] ALERT_MASK_TWO_ADDR = 8'h75;
  localparam logic [7:0] CONFIG_THREE_ADDR   = 8'h78;
  localparam logic [7:0] TIMER_VALUE_ADDR    = 8'h79;
  localparam logic [7:0] TIMER_LIMIT_ADDR    = 8'h7a;
  localparam logic [7:0] CONFIG_FOUR_ADDR    = 8'h7d;

  // ------------------------------------------------------------
  // Reset values.
  // ------------------------------------------------------------
  localparam logic [7:0] ALERT_MASK_RESET    = 8'h00;
  localparam logic [7:0] CONFIG_RESET        = 8'h00;
  localparam logic [7:0] TIMER_LIMIT_RESET   = 8'h00;

  // ------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------
  localparam int STATUS_TWO_SUMMARY_BIT  = 7;
  localparam int CORE_VOLTAGE_FLAG_BIT   = 1;
  localparam int CORE_VOLTAGE_MASK_BIT   = 0;
  localparam int SUPPLY_VOLTAGE_BIT      = 2;
  localparam int THERMAL_TIMER_FLAG_BIT  = 5;
  localparam int ALERT_ENABLE_BIT        = 0;
  localparam int THERMAL_ENABLE_BIT      = 1;
  localparam int BOOST_ENABLE_BIT        = 2;

  // Implemented bits of the two status registers.
  localparam logic [7:0] STATUS_ONE_USED     = 8'h76;
  localparam logic [7:0] STATUS_TWO_USED     = 8'hfe;

  // ------------------------------------------------------------
  // Shared pin function codes.
  // ------------------------------------------------------------
  localparam logic [1:0] PIN_FOURTH_TACH     = 2'h0;
  localparam logic [1:0] PIN_THERMAL_EVENT   = 2'h1;
  localparam logic [1:0] PIN_ALERT_OUTPUT    = 2'h2;
  localparam logic [1:0] PIN_GENERAL_IO      = 2'h3;

  // ------------------------------------------------------------
  // Timing.
  // ------------------------------------------------------------
  localparam int unsigned CLOCK_MHZ          = 40;
  localparam int unsigned TICK_TIME_US       = 22760;
  localparam int unsigned TICK_CYCLES        = TICK_TIME_US * CLOCK_MHZ;

endpackage

// ---- pin_sync_filter.sv ----
`timescale 1ns/1ps

module pin_sync_filter #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_resetn,
  // Pin and filtered level
  input  wire logic i_pin,
  output logic      o_level
);

  logic stage_one_q;
  logic stage_two_q;
  logic stage_three_q;
  logic level_q;

  // ------------------------------------------------------------
  // Three stages; the level moves once stages two and three agree.
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      stage_one_q   <= IDLE_LEVEL;
      stage_two_q   <= IDLE_LEVEL;
      stage_three_q <= IDLE_LEVEL;
      level_q       <= IDLE_LEVEL;
    end
    else
    begin
      stage_one_q   <= i_pin;
      stage_two_q   <= stage_one_q;
      stage_three_q <= stage_two_q;
      if (stage_two_q == stage_three_q)
      begin
        level_q <= stage_three_q;
      end
    end
  end

  assign o_level = level_q;

endmodule

// ---- thermal_timer.sv ----
`timescale 1ns/1ps

module thermal_timer #(
  parameter int unsigned TICK_CYCLES = alert_thermal_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  // Control
  input  wire logic       i_active,
  input  wire logic       i_read_clear,
  // Timer value
  output logic [7:0]      o_value
);

  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  logic             seen_q;
  logic [7:0]       count_q;
  logic [PRE_W-1:0] pre_q;

  if (TICK_CYCLES < 1)
  begin : g_check
    $error("thermal_timer needs at least one cycle per tick.");
  end

  // ------------------------------------------------------------
  // Accumulating tick counter.
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      seen_q  <= 1'b0;
      count_q <= 8'h00;
      pre_q   <= '0;
    end
    else if (i_read_clear)
    begin
      seen_q  <= i_active;
      count_q <= 8'h00;
      pre_q   <= '0;
    end
    else if (i_active)
    begin
      seen_q <= 1'b1;
      if (pre_q == PRE_LAST)
      begin
        pre_q <= '0;
        if (count_q != 8'hff)
        begin
          count_q <= count_q + 8'h01;
        end
      end
      else
      begin
        pre_q <= pre_q + PRE_W'(1);
      end
    end
  end

  // Bit 0 marks the first assertion until the count reaches two ticks.
  assign o_value = (count_q > 8'h01) ? count_q : {7'h00, seen_q};

endmodule

// ---- alert_thermal_timer.sv ----
// Behaviour
// - Status bit sticks until cause gone and read.
// - Alert held while unmasked source or unread status.
// - Mask blocks alert only, status still sets.
// - First mask register bit layout.
// - Second mask register bit layout.
// - Alert off at reset; config bit routes pin5.
// - Two config bits choose shared pin function.
// - Timer monitoring needs thermal enable bit too.
// - Boost runs running fans full while input low.
// - Boost clear leaves fans at present settings.
// - Timer counts during assertion, pauses, accumulates.
// - Timer clears on read, saturates at full.
// - Bit 0 first assertion, then 22.76 ms LSB.
// - Read during assertion restarts with bit 0 set.
// - Timer value compared with 8-bit limit.
// - Over limit sets status bit five and alerts.
// - Limit zero alerts at once, one after 45.52.
// - Status one bit 7 summarises status two.
// - Status two bit 5: fan four or timer.
`timescale 1ns/1ps

module alert_thermal_timer #(
  parameter int unsigned TICK_CYCLES = alert_thermal_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  // Register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_write,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_read,
  output logic [7:0]      o_reg_rdata,
  // Limit comparison results
  input  wire logic [7:0] i_status_one_cond,
  input  wire logic [7:0] i_status_two_cond,
  // Fan control
  input  wire logic       i_fan_running,
  output logic            o_fan_boost,
  // Pins
  input  wire logic       i_pin9_in,
  output logic            o_pin5_alert_out,
  output logic            o_pin5_alert_oe,
  output logic            o_pin9_alert_out,
  output logic            o_pin9_alert_oe
);

  logic [7:0] alert_mask_one_q;
  logic [7:0] alert_mask_two_q;
  logic [7:0] config_three_q;
  logic [7:0] thermal_timer_limit_q;
  logic [7:0] config_four_q;
  logic [7:0] status_one_q;
  logic [7:0] status_two_q;
  logic [7:0] rdata_q;
  logic       boost_q;
  logic       alert_n_q;
  logic       pin5_oe_q;
  logic       pin9_oe_q;

  logic       pin9_level;
  logic       thermal_mode;
  logic       thermal_low;
  logic       timer_read;
  logic [7:0] timer_value;
  logic       timer_over;
  logic [7:0] status_one_view;
  logic [7:0] status_two_set;
  logic       alert_any;

  // ------------------------------------------------------------
  // Thermal input path.
  // ------------------------------------------------------------
  pin_sync_filter #(
    .IDLE_LEVEL (1'b1)
  ) u_pin9_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_pin    (i_pin9_in),
    .o_level  (pin9_level)
  );

  assign thermal_mode = (config_four_q[1:0] == alert_thermal_pkg::PIN_THERMAL_EVENT) &&
                        config_three_q[alert_thermal_pkg::THERMAL_ENABLE_BIT];
  assign thermal_low  = thermal_mode && !pin9_level;
  assign timer_read   = i_reg_read && (i_reg_addr == alert_thermal_pkg::TIMER_VALUE_ADDR);

  thermal_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .i_clock      (i_clock),
    .i_resetn     (i_resetn),
    .i_active     (thermal_low),
    .i_read_clear (timer_read),
    .o_value      (timer_value)
  );

  assign timer_over = timer_value > thermal_timer_limit_q;

  // ------------------------------------------------------------
  // Writable registers.
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      alert_mask_one_q      <= alert_thermal_pkg::ALERT_MASK_RESET;
      alert_mask_two_q      <= alert_thermal_pkg::ALERT_MASK_RESET;
      config_three_q        <= alert_thermal_pkg::CONFIG_RESET;
      thermal_timer_limit_q <= alert_thermal_pkg::TIMER_LIMIT_RESET;
      config_four_q         <= alert_thermal_pkg::CONFIG_RESET;
    end
    else if (i_reg_write)
    begin
      case (i_reg_addr)
        alert_thermal_pkg::ALERT_MASK_ONE_ADDR: alert_mask_one_q <= i_reg_wdata;
        alert_thermal_pkg::ALERT_MASK_TWO_ADDR: alert_mask_two_q <= i_reg_wdata;
        alert_thermal_pkg::CONFIG_THREE_ADDR:   config_three_q <= i_reg_wdata;
        alert_thermal_pkg::TIMER_LIMIT_ADDR:    thermal_timer_limit_q <= i_reg_wdata;
        alert_thermal_pkg::CONFIG_FOUR_ADDR:    config_four_q <= i_reg_wdata;
        default:                                config_four_q <= config_four_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sticky status; a new cause wins over a read in the same cycle.
  // ------------------------------------------------------------
  always_comb
  begin
    status_two_set = i_status_two_cond & alert_thermal_pkg::STATUS_TWO_USED;
    status_two_set[alert_thermal_pkg::THERMAL_TIMER_FLAG_BIT] =
      thermal_mode ? timer_over
                   : i_status_two_cond[alert_thermal_pkg::THERMAL_TIMER_FLAG_BIT];
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      status_one_q <= 8'h00;
      status_two_q <= 8'h00;
    end
    else
    begin
      if (i_reg_read && (i_reg_addr == alert_thermal_pkg::STATUS_ONE_ADDR))
      begin
        status_one_q <= i_status_one_cond & alert_thermal_pkg::STATUS_ONE_USED;
      end
      else
      begin
        status_one_q <= status_one_q |
                        (i_status_one_cond & alert_thermal_pkg::STATUS_ONE_USED);
      end
      if (i_reg_read && (i_reg_addr == alert_thermal_pkg::STATUS_TWO_ADDR))
      begin
        status_two_q <= status_two_set;
      end
      else
      begin
        status_two_q <= status_two_q | status_two_set;
      end
    end
  end

  always_comb
  begin
    status_one_view = status_one_q;
    status_one_view[alert_thermal_pkg::STATUS_TWO_SUMMARY_BIT] = |status_two_q;
  end

  // ------------------------------------------------------------
  // Alert combination.
  // ------------------------------------------------------------
  always_comb
  begin
    alert_any = 1'b0;
    for (int b = 4; b <= 6; b++)
    begin
      alert_any = alert_any | (status_one_q[b] & !alert_mask_one_q[b]);
    end
    alert_any = alert_any |
      (status_one_q[alert_thermal_pkg::SUPPLY_VOLTAGE_BIT] &
       !alert_mask_one_q[alert_thermal_pkg::SUPPLY_VOLTAGE_BIT]) |
      (status_one_q[alert_thermal_pkg::CORE_VOLTAGE_FLAG_BIT] &
       !alert_mask_one_q[alert_thermal_pkg::CORE_VOLTAGE_MASK_BIT]);
    alert_any = alert_any |
      ((|(status_two_q & ~alert_mask_two_q)) &
       !alert_mask_one_q[alert_thermal_pkg::STATUS_TWO_SUMMARY_BIT]);
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      alert_n_q <= 1'b1;
      pin5_oe_q <= 1'b0;
      pin9_oe_q <= 1'b0;
    end
    else
    begin
      alert_n_q <= !alert_any;
      pin5_oe_q <= alert_any && config_three_q[alert_thermal_pkg::ALERT_ENABLE_BIT];
      pin9_oe_q <= alert_any &&
                   (config_four_q[1:0] == alert_thermal_pkg::PIN_ALERT_OUTPUT);
    end
  end

  // ------------------------------------------------------------
  // Fan boost.
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      boost_q <= 1'b0;
    end
    else
    begin
      boost_q <= config_three_q[alert_thermal_pkg::BOOST_ENABLE_BIT] &&
                 thermal_low && i_fan_running;
    end
  end

  // ------------------------------------------------------------
  // Read data.
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rdata_q <= 8'h00;
    end
    else if (i_reg_read)
    begin
      case (i_reg_addr)
        alert_thermal_pkg::STATUS_ONE_ADDR:     rdata_q <= status_one_view;
        alert_thermal_pkg::STATUS_TWO_ADDR:     rdata_q <= status_two_q;
        alert_thermal_pkg::ALERT_MASK_ONE_ADDR: rdata_q <= alert_mask_one_q;
        alert_thermal_pkg::ALERT_MASK_TWO_ADDR: rdata_q <= alert_mask_two_q;
        alert_thermal_pkg::CONFIG_THREE_ADDR:   rdata_q <= config_three_q;
        alert_thermal_pkg::TIMER_VALUE_ADDR:    rdata_q <= timer_value;
        alert_thermal_pkg::TIMER_LIMIT_ADDR:    rdata_q <= thermal_timer_limit_q;
        alert_thermal_pkg::CONFIG_FOUR_ADDR:    rdata_q <= config_four_q;
        default:                                rdata_q <= 8'h00;
      endcase
    end
  end

  assign o_reg_rdata      = rdata_q;
  assign o_fan_boost      = boost_q;
  assign o_pin5_alert_out = alert_n_q;
  assign o_pin5_alert_oe  = pin5_oe_q;
  assign o_pin9_alert_out = alert_n_q;
  assign o_pin9_alert_oe  = pin9_oe_q;

  // ------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  chk_status_sticky_hold: assert property (
    status_one_q[4] && !(i_reg_read && i_reg_addr == alert_thermal_pkg::STATUS_ONE_ADDR)
    |=> status_one_q[4])
    else $error("Status bit dropped without a read.");

  chk_masked_still_sets: assert property (
    i_status_two_cond[7] && alert_mask_two_q[7] |=> status_two_q[7])
    else $error("Masked source did not set its status bit.");

  chk_alert_follows_status: assert property (
    status_one_q[5] && !alert_mask_one_q[5] |=> !alert_n_q)
    else $error("Alert not asserted for unmasked status.");

  chk_full_mask_quiet: assert property (
    alert_mask_one_q == 8'hff && alert_mask_two_q == 8'hff |=> alert_n_q)
    else $error("Alert asserted with every source masked.");

  chk_summary_readback: assert property (
    i_reg_read && i_reg_addr == alert_thermal_pkg::STATUS_ONE_ADDR
    |=> o_reg_rdata[7] == (|$past(status_two_q)))
    else $error("Summary bit disagrees with second status.");

  chk_pin5_gated: assert property (
    !config_three_q[alert_thermal_pkg::ALERT_ENABLE_BIT] |=> !o_pin5_alert_oe)
    else $error("Pin five driven while alert disabled.");

  chk_boost_on: assert property (
    config_three_q[2] && thermal_low && i_fan_running |=> o_fan_boost)
    else $error("Boost missing during thermal event.");

  chk_boost_off: assert property (
    !config_three_q[2] |=> !o_fan_boost)
    else $error("Boost asserted while boost disabled.");

  chk_timer_gated: assert property (
    !thermal_mode && !timer_read |=> $stable(timer_value))
    else $error("Timer moved while thermal input disabled.");

  chk_timer_over_flag: assert property (
    thermal_mode && timer_over |=> status_two_q[5])
    else $error("Timer over limit did not set status bit five.");

  chk_read_restart: assert property (
    timer_read && thermal_low ##1 thermal_low |-> timer_value == 8'h01)
    else $error("Timer read during assertion did not restart at one.");

  cov_alert_pin5: cover property (o_pin5_alert_oe);
  cov_boost: cover property (o_fan_boost);
  cov_timer_flag: cover property (thermal_mode && status_two_q[5]);

endmodule

// ---- thermal_event_source.sv ----
`timescale 1ns/1ps

module thermal_event_source (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // Command
  input  wire logic        i_start,
  input  wire logic [11:0] i_cycles,
  // Pin side
  output logic             o_pin,
  output logic             o_busy
);
  logic [11:0] left_q;

  // Holds the line low for exactly the commanded number of cycles.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      left_q <= 12'h000;
    else if (i_start)
      left_q <= i_cycles;
    else if (left_q != 12'h000)
      left_q <= left_q - 12'h001;
  end

  // A released line returns to its pull-up level.
  assign o_busy = (left_q != 12'h000);
  assign o_pin  = o_busy ? 1'b0 : 1'b1;
endmodule

// ---- alert_and_thermal_timer_test.sv ----
`timescale 1ns/1ps

module alert_and_thermal_timer_test;
  // ------------------------------------------------------------
  // Signals.
  // ------------------------------------------------------------
  logic        i_clock = 1'b0;
  logic        i_resetn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_write = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_read = 1'b0;
  logic [7:0]  reg_rdata;
  logic [7:0]  cond_one = 8'h00;
  logic [7:0]  cond_two = 8'h00;
  logic        fan_running = 1'b0;
  logic        fan_boost;
  logic        pin9;
  logic        p5_out;
  logic        p5_oe;
  logic        p9_out;
  logic        p9_oe;
  logic        ev_start = 1'b0;
  logic [11:0] ev_cycles = 12'h000;
  logic        ev_busy;
  logic [7:0]  rd;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [7:0]  c1 [5] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h02};
  logic [7:0]  m1 [5] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h01};
  logic [7:0]  ra [4] = '{8'h74, 8'h75, 8'h7a, 8'h7d};

  always #12.5 i_clock = ~i_clock;

  // ------------------------------------------------------------
  // Design and far side.
  // ------------------------------------------------------------
  alert_thermal_timer #(.TICK_CYCLES(8)) dut_u (
    .i_clock(i_clock), .i_resetn(i_resetn),
    .i_reg_addr(reg_addr), .i_reg_write(reg_write), .i_reg_wdata(reg_wdata),
    .i_reg_read(reg_read), .o_reg_rdata(reg_rdata),
    .i_status_one_cond(cond_one), .i_status_two_cond(cond_two),
    .i_fan_running(fan_running), .o_fan_boost(fan_boost), .i_pin9_in(pin9),
    .o_pin5_alert_out(p5_out), .o_pin5_alert_oe(p5_oe),
    .o_pin9_alert_out(p9_out), .o_pin9_alert_oe(p9_oe)
  );

  thermal_event_source event_u (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_start(ev_start),
    .i_cycles(ev_cycles), .o_pin(pin9), .o_busy(ev_busy)
  );

  // ------------------------------------------------------------
  // Tasks.
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d.", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge i_clock);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge i_clock);
    reg_read <= 1'b0;
    @(posedge i_clock);
    #1 d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    reg_rd(a, v);
    check(v, e);
  endtask

  task automatic settle();
    repeat (3) @(posedge i_clock);
    #1;
  endtask

  task automatic cond_pulse(input logic two, input logic [7:0] v);
    @(posedge i_clock);
    if (two) cond_two <= v;
    else cond_one <= v;
    @(posedge i_clock);
    cond_one <= 8'h00;
    cond_two <= 8'h00;
    settle();
  endtask

  task automatic ev_go(input logic [11:0] n);
    @(posedge i_clock);
    ev_start  <= 1'b1;
    ev_cycles <= n;
    @(posedge i_clock);
    ev_start <= 1'b0;
  endtask

  task automatic ev_run(input logic [11:0] n);
    int k;
    ev_go(n);
    @(posedge i_clock);
    for (k = 0; k < 4200 && ev_busy === 1'b1; k++)
      @(posedge i_clock);
    if (k == 4200)
    begin
      n_mismatch++;
      $display("Error at %0t: thermal event never ended", $time);
      end_sim();
    end
    repeat (8) @(posedge i_clock);
    #1;
  endtask

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge i_clock);
    i_resetn <= 1'b1;
    settle();
    check({6'h00, p5_oe, p9_oe}, 8'h00);
    check({6'h00, p5_out, p9_out}, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      rd_chk(ra[i], 8'h00);
      reg_wr(ra[i], 8'ha5);
      rd_chk(ra[i], 8'ha5);
      reg_wr(ra[i], 8'h00);
    end
    rd_chk(8'h78, 8'h00);
    reg_wr(8'h79, 8'h33);
    rd_chk(8'h79, 8'h00);
    rd_chk(8'h50, 8'h00);
    // Sticky status and alert on pin 5.
    reg_wr(8'h78, 8'h01);
    cond_pulse(1'b0, 8'h20);
    check({6'h00, p5_oe, p5_out}, 8'h02);
    rd_chk(8'h41, 8'h20);
    rd_chk(8'h41, 8'h00);
    settle();
    check({7'h00, p5_oe}, 8'h00);
    @(posedge i_clock);
    cond_one <= 8'h10;
    rd_chk(8'h41, 8'h10);
    rd_chk(8'h41, 8'h10);
    settle();
    check({7'h00, p5_oe}, 8'h01);
    // Shared pin function codes with an alert pending.
    for (int c = 0; c < 4; c++)
    begin
      reg_wr(8'h7d, c[7:0]);
      settle();
      check({7'h00, p9_oe}, {7'h00, c == 2});
      check({7'h00, p9_out}, 8'h00);
    end
    reg_wr(8'h7d, 8'h00);
    @(posedge i_clock);
    cond_one <= 8'h00;
    rd_chk(8'h41, 8'h10);
    rd_chk(8'h41, 8'h00);
    // Each mask bit blocks the alert only.
    for (int i = 0; i < 5; i++)
    begin
      reg_wr(8'h74, m1[i]);
      cond_pulse(1'b0, c1[i]);
      check({7'h00, p5_oe}, 8'h00);
      rd_chk(8'h41, c1[i]);
    end
    reg_wr(8'h74, 8'h00);
    for (int b = 1; b < 8; b++)
    begin
      reg_wr(8'h75, 8'h01 << b);
      cond_pulse(1'b1, 8'h01 << b);
      check({7'h00, p5_oe}, 8'h00);
      rd_chk(8'h41, 8'h80);
      rd_chk(8'h42, 8'h01 << b);
    end
    reg_wr(8'h75, 8'h00);
    reg_wr(8'h74, 8'h80);
    cond_pulse(1'b1, 8'h08);
    check({7'h00, p5_oe}, 8'h00);
    reg_wr(8'h74, 8'h00);
    settle();
    check({7'h00, p5_oe}, 8'h01);
    rd_chk(8'h42, 8'h08);
    rd_chk(8'h41, 8'h00);
    // Thermal timer needs the enable bit as well.
    reg_wr(8'h7d, 8'h01);
    reg_wr(8'h78, 8'h00);
    ev_run(12'd20);
    rd_chk(8'h79, 8'h00);
    reg_wr(8'h75, 8'h20);
    reg_wr(8'h78, 8'h03);
    ev_run(12'd4);
    rd_chk(8'h79, 8'h01);
    ev_run(12'd20);
    ev_run(12'd8);
    check({7'h00, p5_oe}, 8'h00);
    rd_chk(8'h79, 8'h03);
    rd_chk(8'h79, 8'h00);
    rd_chk(8'h42, 8'h20);
    rd_chk(8'h42, 8'h00);
    ev_go(12'd40);
    repeat (20) @(posedge i_clock);
    reg_rd(8'h79, rd);
    check(rd, 8'h02);
    rd_chk(8'h79, 8'h01);
    rd_chk(8'h42, 8'h20);
    ev_run(12'd1);
    ev_run(12'd2100);
    rd_chk(8'h79, 8'hff);
    reg_rd(8'h42, rd);
    check(rd, 8'h20);
    rd_chk(8'h42, 8'h00);
    // Timer limit of one with the host's service order.
    reg_wr(8'h7a, 8'h01);
    reg_wr(8'h75, 8'h00);
    ev_run(12'd12);
    check({7'h00, p5_oe}, 8'h00);
    ev_run(12'd10);
    check({6'h00, p5_oe, p5_out}, 8'h02);
    rd_chk(8'h42, 8'h20);
    reg_wr(8'h75, 8'h20);
    settle();
    check({7'h00, p5_oe}, 8'h00);
    rd_chk(8'h79, 8'h02);
    rd_chk(8'h42, 8'h20);
    rd_chk(8'h42, 8'h00);
    reg_wr(8'h75, 8'h00);
    settle();
    check({7'h00, p5_oe}, 8'h00);
    // Fan boost on thermal events.
    reg_wr(8'h78, 8'h06);
    @(posedge i_clock);
    fan_running <= 1'b1;
    ev_go(12'd30);
    repeat (12) @(posedge i_clock);
    #1 check({7'h00, fan_boost}, 8'h01);
    @(posedge i_clock);
    fan_running <= 1'b0;
    settle();
    check({7'h00, fan_boost}, 8'h00);
    ev_run(12'd1);
    check({7'h00, fan_boost}, 8'h00);
    reg_wr(8'h78, 8'h02);
    @(posedge i_clock);
    fan_running <= 1'b1;
    ev_go(12'd30);
    repeat (12) @(posedge i_clock);
    #1 check({7'h00, fan_boost}, 8'h00);
    ev_run(12'd1);
    end_sim();
  end
endmodule
